//--- sfpw_pkg.sv
// Purpose: Shared constants and types for the synthesizer frequency and phase word bank
// Assumes: 32-bit serial words, four low bits select the target register
// Notes: Field positions are bit indices inside the received word
package sfpw_pkg;

    // Word geometry
    localparam int WORD_W = 32;
    localparam int ADDR_W = 4;
    localparam int CNT_W = 6;
    localparam logic [5:0] WORD_LAST = 6'h1f;

    // Register addresses carried in the word address bits
    localparam logic [3:0] ADDR_DIVIDE = 4'h0;
    localparam logic [3:0] ADDR_MAIN = 4'h1;
    localparam logic [3:0] ADDR_AUX = 4'h2;
    localparam logic [3:0] ADDR_PHASE = 4'h3;

    // Divide word fields
    localparam int INT_LSB = 4;
    localparam int INT_W = 16;
    localparam int PRESCALER_BIT = 20;
    localparam int CAL_BIT = 21;

    // Main fraction word fields
    localparam int MAIN_LSB = 4;
    localparam int MAIN_W = 24;

    // Aux fraction word fields
    localparam int AUX_DEN_LSB = 4;
    localparam int AUX_NUM_LSB = 18;
    localparam int AUX_W = 14;

    // Phase control word fields
    localparam int PHASE_LSB = 4;
    localparam int PHASE_W = 24;
    localparam int STEP_BIT = 28;
    localparam int RESYNC_BIT = 29;
    localparam int SDRST_DIS_BIT = 30;

    // Values after reset
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [23:0] PHASE_RESET = 24'h00_0000;
    localparam logic [2:0] SYNC_RESET = 3'h0;

    // Update engine states
    typedef enum logic [2:0] {
        SFPW_IDLE = 3'b001,
        SFPW_DECODE = 3'b010,
        SFPW_APPLY = 3'b100
    } sfpw_state_e;

    // Settings that the synthesizer core consumes
    typedef struct packed {
        logic [15:0] int_value;
        logic prescaler_89;
        logic band_calibration_enable;
        logic [23:0] main_partial_numerator;
        logic [13:0] aux_partial_numerator;
        logic [13:0] aux_partial_denominator;
        logic modulator_reset_disable;
        logic phase_resync_enable;
        logic phase_step_enable;
        logic [23:0] phase_value;
    } sfpw_cfg_s;

    // One-cycle events towards the core
    typedef struct packed {
        logic modulator_reset;
        logic resync_fire;
        logic divide_update;
    } sfpw_evt_s;

endpackage : sfpw_pkg

//--- sfpw_link_shift.sv
// Purpose: Serial word capture on the link clock
// Assumes: Data is shifted MSB first on rising link clock edges while the latch line is low
// Notes: A full word is held stable and announced by a toggle for the system clock side
`timescale 1ns/1ps
module sfpw_link_shift (
    input wire logic sclk,
    input wire logic srst,
    input wire logic latch_en,
    input wire logic sdata,
    output logic [31:0] word_q,
    output logic word_tgl_q
);

    logic [31:0] shift_q; // Shift register
    logic [31:0] shift_d;
    logic [5:0] cnt_q; // Bits taken in this frame
    logic [5:0] cnt_d;
    logic [31:0] word_d;
    logic word_tgl_d;
    logic frame_clr; // Frame end or system reset

    // The latch line ends the frame, so no link edge is needed to clear the count
    assign frame_clr = latch_en | srst;

    // Next values of shift, count and handover word
    always_comb begin
        shift_d = {shift_q[30:0], sdata};
        cnt_d = cnt_q + 6'h01;
        word_d = word_q;
        word_tgl_d = word_tgl_q;
        if (cnt_q == sfpw_pkg::WORD_LAST) begin
            // Last bit: hand the word over and restart the count
            word_d = {shift_q[30:0], sdata};
            word_tgl_d = ~word_tgl_q;
            cnt_d = 6'h00;
        end
    end

    // Shift register, no reset needed
    always_ff @(posedge sclk) begin
        shift_q <= shift_d;
    end

    // Bit count, cleared between frames
    always_ff @(posedge sclk or posedge frame_clr) begin
        if (frame_clr) begin
            cnt_q <= 6'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Handover word and toggle
    always_ff @(posedge sclk or posedge srst) begin
        if (srst) begin
            word_q <= sfpw_pkg::WORD_RESET;
            word_tgl_q <= 1'b0;
        end else begin
            word_q <= word_d;
            word_tgl_q <= word_tgl_d;
        end
    end

endmodule : sfpw_link_shift

//--- sfpw_phase_accum.sv
// Purpose: Output phase offset accumulator
// Assumes: Step pulses come from the system clock domain
// Notes: Wraps at a full turn, one count is one 2^24th of a turn
`timescale 1ns/1ps
module sfpw_phase_accum (
    input wire logic clk,
    input wire logic srst,
    input wire logic step,
    input wire logic [23:0] inc,
    output logic [23:0] phase_q
);

    logic [23:0] phase_d;

    // Modulo 2^24 add on each step
    always_comb begin
        phase_d = phase_q;
        if (step) begin
            phase_d = phase_q + inc;
        end
    end

    // Phase register
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_q <= sfpw_pkg::PHASE_RESET;
        end else begin
            phase_q <= phase_d;
        end
    end

endmodule : sfpw_phase_accum

//--- sfpw_regs.sv
// Purpose: Frequency and phase control word bank with staged update
// Assumes: Host shifts 32-bit words on its own link clock and frames them with the latch line
// Notes: Fraction and phase words wait in stages until the divide word is written
`timescale 1ns/1ps
module sfpw_regs (
    input wire logic clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic latch_en,
    input wire logic sdata,
    output sfpw_pkg::sfpw_cfg_s cfg_q,
    output sfpw_pkg::sfpw_evt_s evt_q,
    output logic [23:0] phase_offset_q,
    output logic resync_active_q
);

    // Address decode used by the write path only; the state path never decodes the address
    function automatic logic addr_is(input logic [31:0] w, input logic [3:0] a);
        addr_is = (w[3:0] == a);
    endfunction : addr_is

    logic [31:0] link_word; // Word held by the link side
    logic link_tgl; // Toggles once per complete word
    logic [2:0] sync_q; // Toggle synchroniser, stage 0 first
    logic [2:0] sync_d;
    logic seen_q; // Last toggle level acted on
    logic seen_d;
    logic new_word; // Settled toggle change
    logic [31:0] rx_q; // Word copied into the system domain
    logic [31:0] rx_d;
    sfpw_pkg::sfpw_state_e state_q; // Update engine state
    sfpw_pkg::sfpw_state_e state_d;
    logic [31:0] div_q; // Divide word, acts at once
    logic [31:0] div_d;
    logic [31:0] main_stage_q; // Staged main fraction word
    logic [31:0] main_stage_d;
    logic [31:0] aux_stage_q; // Staged aux fraction word
    logic [31:0] aux_stage_d;
    logic [31:0] phase_stage_q; // Staged phase word
    logic [31:0] phase_stage_d;
    logic [31:0] main_act_q; // Active main fraction word
    logic [31:0] main_act_d;
    logic [31:0] aux_act_q; // Active aux fraction word
    logic [31:0] aux_act_d;
    logic [31:0] phase_act_q; // Active phase word
    logic [31:0] phase_act_d;
    sfpw_pkg::sfpw_evt_s evt_d;
    logic resync_active_d;
    logic phase_step; // Advance the phase accumulator

    // Link side capture on the host clock
    sfpw_link_shift u_link (
        .sclk(sclk),
        .srst(srst),
        .latch_en(latch_en),
        .sdata(sdata),
        .word_q(link_word),
        .word_tgl_q(link_tgl)
    );

    // Toggle crossing: stage 0 feeds only stage 1
    always_comb begin
        sync_d = {sync_q[1:0], link_tgl};
        new_word = (sync_q[1] == sync_q[2]) && (sync_q[2] != seen_q);
        seen_d = new_word ? sync_q[2] : seen_q;
    end

    // Synchroniser registers
    always_ff @(posedge clk) begin
        if (srst) begin
            sync_q <= sfpw_pkg::SYNC_RESET;
            seen_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            seen_q <= seen_d;
        end
    end

    // Update engine: copy the held word, decode it, then apply
    always_comb begin
        state_d = state_q;
        rx_d = rx_q;
        case (state_q)
            sfpw_pkg::SFPW_IDLE: begin
                // Held word is stable once the toggle has settled
                if (new_word) begin
                    rx_d = link_word;
                    state_d = sfpw_pkg::SFPW_DECODE;
                end
            end
            sfpw_pkg::SFPW_DECODE: begin
                state_d = sfpw_pkg::SFPW_APPLY;
            end
            sfpw_pkg::SFPW_APPLY: begin
                state_d = sfpw_pkg::SFPW_IDLE;
            end
            default: begin
                state_d = sfpw_pkg::SFPW_IDLE;
            end
        endcase
    end

    // Engine registers
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= sfpw_pkg::SFPW_IDLE;
            rx_q <= sfpw_pkg::WORD_RESET;
        end else begin
            state_q <= state_d;
            rx_q <= rx_d;
        end
    end

    // Register writes and staged transfer
    always_comb begin
        div_d = div_q;
        main_stage_d = main_stage_q;
        aux_stage_d = aux_stage_q;
        phase_stage_d = phase_stage_q;
        main_act_d = main_act_q;
        aux_act_d = aux_act_q;
        phase_act_d = phase_act_q;
        evt_d = '0;
        phase_step = 1'b0;
        if (state_q == sfpw_pkg::SFPW_APPLY) begin
            // Unknown addresses are dropped
            if (addr_is(rx_q, sfpw_pkg::ADDR_DIVIDE)) begin
                div_d = rx_q;
                // Staged words become active together
                main_act_d = main_stage_q;
                aux_act_d = aux_stage_q;
                phase_act_d = phase_stage_q;
                evt_d.divide_update = 1'b1;
                // Reset disable taken from the word being applied
                evt_d.modulator_reset = ~phase_stage_q[sfpw_pkg::SDRST_DIS_BIT];
                // Resync fires only with its enable and a zero aux numerator
                evt_d.resync_fire = phase_stage_q[sfpw_pkg::RESYNC_BIT]
                    && (aux_stage_q[sfpw_pkg::AUX_NUM_LSB +: sfpw_pkg::AUX_W] == 14'h0000);
                phase_step = phase_stage_q[sfpw_pkg::STEP_BIT];
            end else if (addr_is(rx_q, sfpw_pkg::ADDR_MAIN)) begin
                main_stage_d = rx_q;
            end else if (addr_is(rx_q, sfpw_pkg::ADDR_AUX)) begin
                aux_stage_d = rx_q;
            end else if (addr_is(rx_q, sfpw_pkg::ADDR_PHASE)) begin
                phase_stage_d = rx_q;
            end
        end
    end

    // Word registers and event pulses
    always_ff @(posedge clk) begin
        if (srst) begin
            div_q <= sfpw_pkg::WORD_RESET;
            main_stage_q <= sfpw_pkg::WORD_RESET;
            aux_stage_q <= sfpw_pkg::WORD_RESET;
            phase_stage_q <= sfpw_pkg::WORD_RESET;
            main_act_q <= sfpw_pkg::WORD_RESET;
            aux_act_q <= sfpw_pkg::WORD_RESET;
            phase_act_q <= sfpw_pkg::WORD_RESET;
            evt_q <= '0;
        end else begin
            div_q <= div_d;
            main_stage_q <= main_stage_d;
            aux_stage_q <= aux_stage_d;
            phase_stage_q <= phase_stage_d;
            main_act_q <= main_act_d;
            aux_act_q <= aux_act_d;
            phase_act_q <= phase_act_d;
            evt_q <= evt_d;
        end
    end

    // Field extraction for the core, all from registers
    always_comb begin
        cfg_q.int_value = div_q[sfpw_pkg::INT_LSB +: sfpw_pkg::INT_W];
        cfg_q.prescaler_89 = div_q[sfpw_pkg::PRESCALER_BIT];
        cfg_q.band_calibration_enable = div_q[sfpw_pkg::CAL_BIT];
        cfg_q.main_partial_numerator = main_act_q[sfpw_pkg::MAIN_LSB +: sfpw_pkg::MAIN_W];
        cfg_q.aux_partial_numerator = aux_act_q[sfpw_pkg::AUX_NUM_LSB +: sfpw_pkg::AUX_W];
        cfg_q.aux_partial_denominator = aux_act_q[sfpw_pkg::AUX_DEN_LSB +: sfpw_pkg::AUX_W];
        cfg_q.modulator_reset_disable = phase_act_q[sfpw_pkg::SDRST_DIS_BIT];
        cfg_q.phase_resync_enable = phase_act_q[sfpw_pkg::RESYNC_BIT];
        cfg_q.phase_step_enable = phase_act_q[sfpw_pkg::STEP_BIT];
        cfg_q.phase_value = phase_act_q[sfpw_pkg::PHASE_LSB +: sfpw_pkg::PHASE_W];
    end

    // Resync readiness level for the core
    always_comb begin
        resync_active_d = phase_act_q[sfpw_pkg::RESYNC_BIT]
            && (aux_act_q[sfpw_pkg::AUX_NUM_LSB +: sfpw_pkg::AUX_W] == 14'h0000);
    end

    // Resync readiness register
    always_ff @(posedge clk) begin
        if (srst) begin
            resync_active_q <= 1'b0;
        end else begin
            resync_active_q <= resync_active_d;
        end
    end

    // Phase offset grows by the phase value on each stepping update
    sfpw_phase_accum u_phase (
        .clk(clk),
        .srst(srst),
        .step(phase_step),
        .inc(phase_stage_q[sfpw_pkg::PHASE_LSB +: sfpw_pkg::PHASE_W]),
        .phase_q(phase_offset_q)
    );

    // Checks on the system clock side
    a_int_field: assert property (@(posedge clk) disable iff (srst)
        evt_q.divide_update |-> cfg_q.int_value == $past(rx_q[19:4]))
        else $error("integer value not taken from bits 19:4");

    a_prescaler_bit: assert property (@(posedge clk) disable iff (srst)
        evt_q.divide_update |-> cfg_q.prescaler_89 == $past(rx_q[20]))
        else $error("prescaler not taken from bit 20");

    a_main_staged: assert property (@(posedge clk) disable iff (srst)
        (state_q == sfpw_pkg::SFPW_APPLY && rx_q[3:0] == 4'h1) |=> $stable(main_act_q))
        else $error("main fraction applied without divide write");

    a_main_apply: assert property (@(posedge clk) disable iff (srst)
        evt_q.divide_update |-> cfg_q.main_partial_numerator == $past(main_stage_q[27:4]))
        else $error("main numerator not applied on divide write");

    a_aux_load: assert property (@(posedge clk) disable iff (srst)
        (state_q == sfpw_pkg::SFPW_APPLY && rx_q[3:0] == 4'h2) |=> aux_stage_q == $past(rx_q))
        else $error("aux word not staged");

    a_aux_den: assert property (@(posedge clk) disable iff (srst)
        evt_q.divide_update |-> cfg_q.aux_partial_denominator == $past(aux_stage_q[17:4]))
        else $error("aux denominator not applied");

    a_phase_load: assert property (@(posedge clk) disable iff (srst)
        (state_q == sfpw_pkg::SFPW_APPLY && rx_q[3:0] == 4'h3) |=> phase_stage_q == $past(rx_q))
        else $error("phase word not staged");

    a_main_load: assert property (@(posedge clk) disable iff (srst)
        (state_q == sfpw_pkg::SFPW_APPLY && rx_q[3:0] == 4'h1) |=> main_stage_q == $past(rx_q))
        else $error("main word not staged");

    a_modrst_pulse: assert property (@(posedge clk) disable iff (srst)
        evt_q.divide_update |-> evt_q.modulator_reset == !cfg_q.modulator_reset_disable)
        else $error("modulator reset disagrees with disable bit");

    a_resync_gate: assert property (@(posedge clk) disable iff (srst)
        evt_q.resync_fire |-> cfg_q.phase_resync_enable && cfg_q.aux_partial_numerator == 14'h0000)
        else $error("resync fired while not allowed");

    a_phase_step: assert property (@(posedge clk) disable iff (srst)
        (evt_q.divide_update && cfg_q.phase_step_enable) |=>
        phase_offset_q == 24'($past(phase_offset_q, 2) + $past(cfg_q.phase_value)))
        else $error("phase did not advance by the phase value");

    a_word_decode: assert property (@(posedge clk) disable iff (srst)
        new_word ##1 (state_q == sfpw_pkg::SFPW_DECODE) ##1 (rx_q[3:0] == 4'h0) |=> evt_q.divide_update)
        else $error("divide word not applied two cycles after decode");

    a_aux_staged: assert property (@(posedge clk) disable iff (srst)
        (state_q == sfpw_pkg::SFPW_APPLY && rx_q[3:0] == 4'h2) |=> $stable(aux_act_q))
        else $error("aux fraction applied without divide write");

    a_phase_staged: assert property (@(posedge clk) disable iff (srst)
        (state_q == sfpw_pkg::SFPW_APPLY && rx_q[3:0] == 4'h3) |=> $stable(phase_act_q))
        else $error("phase word applied without divide write");

    a_phase_value: assert property (@(posedge clk) disable iff (srst)
        evt_q.divide_update |-> cfg_q.phase_value == $past(phase_stage_q[27:4]))
        else $error("phase value not applied on divide write");

    a_phase_hold: assert property (@(posedge clk) disable iff (srst)
        (evt_q.divide_update && !cfg_q.phase_step_enable) |-> $stable(phase_offset_q))
        else $error("phase moved without phase step enable");

    a_modrst_source: assert property (@(posedge clk) disable iff (srst)
        evt_q.modulator_reset |-> evt_q.divide_update)
        else $error("modulator reset outside a divide write");

    a_unknown_drop: assert property (@(posedge clk) disable iff (srst)
        (state_q == sfpw_pkg::SFPW_APPLY && rx_q[3:0] > 4'h3) |=>
        $stable(div_q) && $stable(main_stage_q) && $stable(aux_stage_q) && $stable(phase_stage_q))
        else $error("unknown address changed a register");

endmodule : sfpw_regs

//--- sfpw_host_model.sv
// Purpose: Host controller model that shifts 32-bit words into the frequency and phase word bank
// Assumes: MSB first, latch line low frames a word, link clock 15 ns and still between frames
// Notes: After a frame the data line shows the inverse of the last bit, never a stale level
`timescale 1ns/1ps
module sfpw_host_model (
    output logic sclk,
    output logic latch_en,
    output logic sdata
);
    // Idle link: clock still, frame line high
    initial begin
        sclk = 1'b0;
        latch_en = 1'b1;
        sdata = 1'b0;
    end

    // Shift one word; reserved bits of main and phase words forced low as the host must send them
    // Resync timer and feedback select live in registers outside this bank
    task automatic send_word(input logic [31:0] w);
        logic [31:0] v;
        v = w;
        if (v[3:0] == 4'h1) begin
            v[31:28] = 4'h0;
        end
        if (v[3:0] == 4'h3) begin
            v[31] = 1'b0;
        end
        // Odd offset keeps the link clock unrelated in phase to the system clock
        #3.3;
        latch_en = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            sdata = v[i];
            #7.5;
            sclk = 1'b1;
            #7.5;
            sclk = 1'b0;
        end
        latch_en = 1'b1;
        // Released data line shows the inverse of the last bit
        sdata = ~v[0];
    endtask : send_word

    // Cut frame: only the top bits, then the frame line rises early
    task automatic send_cut(input logic [31:0] w, input int nbits);
        #3.3;
        latch_en = 1'b0;
        for (int i = 31; i > 31 - nbits; i--) begin
            sdata = w[i];
            #7.5;
            sclk = 1'b1;
            #7.5;
            sclk = 1'b0;
        end
        latch_en = 1'b1;
        // Released data line shows the inverse of the last bit
        sdata = ~w[32 - nbits];
    endtask : send_cut
endmodule : sfpw_host_model

//--- sfpw_regs_tb.sv
// Purpose: Self-checking bench for the frequency and phase word bank
// Assumes: Host model shifts words; system clock 25 MHz
// Notes: Expected settings are tracked from the words the bench sends
`timescale 1ns/1ps
module sfpw_regs_tb;
    logic clk; // System clock
    logic srst; // Synchronous reset
    wire logic sclk; // Link clock from host
    wire logic latch_en; // Frame line from host
    wire logic sdata; // Serial data from host
    sfpw_pkg::sfpw_cfg_s cfg_q; // Active settings
    sfpw_pkg::sfpw_evt_s evt_q; // Update pulses
    logic [23:0] phase_offset_q; // Accumulated phase
    logic resync_active_q; // Resync level
    sfpw_pkg::sfpw_cfg_s stg; // Staged words as sent
    sfpw_pkg::sfpw_cfg_s exp_cfg; // Expected active settings
    logic [23:0] exp_phase; // Expected phase offset
    int miscompares; // Mismatch count
    int checks_done; // Comparison count

    // Device under test
    sfpw_regs u_dut (
        .clk(clk),
        .srst(srst),
        .sclk(sclk),
        .latch_en(latch_en),
        .sdata(sdata),
        .cfg_q(cfg_q),
        .evt_q(evt_q),
        .phase_offset_q(phase_offset_q),
        .resync_active_q(resync_active_q)
    );

    // Far-side host
    sfpw_host_model u_host (
        .sclk(sclk),
        .latch_en(latch_en),
        .sdata(sdata)
    );

    // System clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Compare and count
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Verdict and end of run
    task automatic finish_test();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    // Send a word and let it settle
    task automatic put(input logic [31:0] w);
        u_host.send_word(w);
        repeat (12) @(posedge clk);
        #1;
    endtask : put

    // Staged word writers
    task automatic put_main(input logic [23:0] n);
        stg.main_partial_numerator = n;
        put({4'h0, n, 4'h1});
    endtask : put_main

    task automatic put_aux(input logic [13:0] n, input logic [13:0] d);
        stg.aux_partial_numerator = n;
        stg.aux_partial_denominator = d;
        put({n, d, 4'h2});
    endtask : put_aux

    task automatic put_phase(input logic dis, input logic rsy, input logic stp, input logic [23:0] p);
        stg.modulator_reset_disable = dis;
        stg.phase_resync_enable = rsy;
        stg.phase_step_enable = stp;
        stg.phase_value = p;
        put({1'b0, dis, rsy, stp, p, 4'h3});
    endtask : put_phase

    // Divide word write, then check the applied settings and pulses
    task automatic apply(input logic [15:0] iv, input logic pre, input logic cal,
                         input logic mrst, input logic rfire, input logic ract);
        int n;
        exp_cfg = stg;
        exp_cfg.int_value = iv;
        exp_cfg.prescaler_89 = pre;
        exp_cfg.band_calibration_enable = cal;
        if (stg.phase_step_enable) begin
            exp_phase = exp_phase + stg.phase_value;
        end
        u_host.send_word({10'h000, cal, pre, iv, 4'h0});
        n = 0;
        while (evt_q.divide_update !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        check({127'h0, (n < 40)}, 128'h1);
        check(evt_q, {mrst, rfire, 1'b1});
        check(cfg_q, exp_cfg);
        check(phase_offset_q, exp_phase);
        @(posedge clk);
        #1;
        // Readiness level is registered from the active words, one cycle after the update
        check(resync_active_q, ract);
        check(evt_q, 3'h0);
    endtask : apply

    // Watchdog
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        finish_test();
    end

    // Main sequence
    initial begin
        miscompares = 0;
        checks_done = 0;
        stg = '0;
        exp_cfg = '0;
        exp_phase = 24'h00_0000;
        srst = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        srst = 1'b0;
        @(posedge clk);
        #1;
        check({cfg_q, evt_q, phase_offset_q, resync_active_q}, 128'h0);
        // Staged words stay hidden until a divide write
        put_main(24'hab_cdef);
        put_aux(14'h0123, 14'h3fff);
        put_phase(1'b1, 1'b0, 1'b1, 24'h90_0000);
        check(cfg_q, exp_cfg);
        // Lowest 4/5 integer, then largest 8/9 integer; phase wraps on second step
        apply(16'd23, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        apply(16'hffff, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        // Resync with zero aux numerator and modulator reset enabled
        put_aux(14'h0000, 14'h0005);
        put_phase(1'b0, 1'b1, 1'b0, 24'h00_0001);
        apply(16'd75, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        // Nonzero aux numerator blocks resync
        put_aux(14'h0001, 14'h0005);
        apply(16'd32767, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        // Resync bit clear leaves resync unused
        put_aux(14'h0000, 14'h2abc);
        put_phase(1'b0, 1'b0, 1'b0, 24'h12_3456);
        apply(16'd100, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        // Unknown addresses change nothing
        for (int a = 4; a < 16; a++) begin
            put({28'hfff_ffff, a[3:0]});
            check({cfg_q, evt_q}, {exp_cfg, 3'h0});
        end
        // Cut frame is dropped and the next full word still lines up
        u_host.send_cut(32'hffff_fff0, 20);
        repeat (12) @(posedge clk);
        #1;
        check({cfg_q, evt_q}, {exp_cfg, 3'h0});
        // Staged words untouched by unknown and cut words
        apply(16'd200, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        // Reset in mid-run clears everything
        srst = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        srst = 1'b0;
        check({cfg_q, evt_q, phase_offset_q, resync_active_q}, 128'h0);
        // Link and engine work again after the second reset
        stg = '0;
        exp_phase = 24'h00_0000;
        apply(16'd500, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        finish_test();
    end
endmodule : sfpw_regs_tb
